/* dpc_params.svh */
/*
 * Register offsets, field positions and reset values of the DAC power
 * and cable detect control block.
 * Assumes it is included by bare name from every design file that needs it.
 */
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

`define DPC_ADDR_W 8
`define DPC_DATA_W 8

`define DPC_OFS_LOW_POWER 8'h0D
`define DPC_OFS_CABLE 8'h10
`define DPC_OFS_RB_FIRST 8'h12
`define DPC_OFS_RB_LAST 8'h16
`define DPC_OFS_SWRST 8'h17

`define DPC_LP_MSB 2
`define DPC_LP_LSB 0
`define DPC_CAB_DAC1_BIT 0
`define DPC_CAB_DAC2_BIT 1
`define DPC_CAB_AUTO_BIT 4
`define DPC_SWRST_BIT 1

`define DPC_LP_RST 3'h0
`define DPC_CAB_STAT_RST 2'h3
`define DPC_AUTO_RST 1'h0
`define DPC_PD_RST 3'h0
`define DPC_SPI_RST 1'h0

`define DPC_READ_LATENCY 1

`endif

/* dpc_pkg.sv */
/*
 * Types shared by the DAC power and cable detect control block.
 * Assumes nothing of its surroundings.
 */
package dpc_pkg;

    typedef enum logic [0:0] {
        DPC_CFG_CVBS_YC = 1'b0,
        DPC_CFG_COMPONENT = 1'b1
    } dpc_out_cfg_t;

    typedef logic [2:0] dpc_dac_vec_t;

endpackage : dpc_pkg

/* dpc_sync2.sv */
/*
 * Two flip-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/100ps

module dpc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("dpc_sync2: WIDTH must be at least 1");
        end
    endgenerate

    // First stage feeds only the second stage
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule : dpc_sync2

/* dpc_ctrl.sv */
/*
 * DAC low power enables, once-per-frame cable detection with automatic
 * DAC power-down, input pin readback and self-clearing software reset.
 * Assumes a decoded host-port register access (subaddress, strobes) on
 * the pixel clock, a frame-start strobe from the timing generator on the
 * same clock, and asynchronous pins and analog cable sense levels.
 */
`timescale 1ns/100ps
`include "dpc_params.svh"

module dpc_ctrl #(
    parameter int PIX_W = 10
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [`DPC_ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [`DPC_DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [`DPC_DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_spi_detect,
    output logic o_spi_mode,
    output logic o_soft_reset,
    input wire logic i_frame_start,
    input wire logic i_cable_det_en,
    input wire logic i_out_cfg,
    input wire logic [2:0] i_dac_pwr_up,
    input wire logic [1:0] i_cable_present,
    input wire logic [PIX_W-1:0] i_pix_s,
    input wire logic [PIX_W-1:0] i_pix_y,
    input wire logic [PIX_W-1:0] i_pix_c,
    input wire logic i_s_hsync_n,
    input wire logic i_s_vsync_n,
    input wire logic i_p_hsync_n,
    input wire logic i_p_vsync_n,
    input wire logic i_p_blank_n,
    input wire logic i_subcarrier_lock_or_serial_out,
    output logic [2:0] o_dac_low_power,
    output logic [2:0] o_dac_auto_pd,
    output logic [1:0] o_cable_status,
    output logic o_auto_pd_en
);

    localparam int PIN_W = 3 * PIX_W + 6;
    localparam int SYNC_W = PIN_W + 2;

    generate
        if (PIX_W != 10) begin : g_bad_pix
            $error("dpc_ctrl: readback layout serves only PIX_W of 10");
        end
    endgenerate

    // Host-visible defaults apply on power-on or software reset
    logic soft_rst_q;
    logic regs_rst;
    assign regs_rst = i_srst | soft_rst_q;

    function automatic logic hit(input logic [`DPC_ADDR_W-1:0] a,
                                 input logic [`DPC_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic wr_lp;
    logic wr_cab;
    logic wr_swrst;
    assign wr_lp = i_reg_wr & hit(i_reg_addr, `DPC_OFS_LOW_POWER);
    assign wr_cab = i_reg_wr & hit(i_reg_addr, `DPC_OFS_CABLE);
    assign wr_swrst = i_reg_wr & hit(i_reg_addr, `DPC_OFS_SWRST);

    // Pins and analog sense arrive outside the clock domain
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    assign sync_in = {i_cable_present, i_subcarrier_lock_or_serial_out,
                      i_p_blank_n, i_p_vsync_n, i_p_hsync_n,
                      i_s_vsync_n, i_s_hsync_n, i_pix_c, i_pix_y, i_pix_s};

    dpc_sync2 #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_async(sync_in),
        .o_sync(sync_out)
    );

    logic [1:0] present_s;
    assign present_s = sync_out[SYNC_W-1 -: 2];

    // Software reset: one-cycle pulse, never stored as readable state
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= wr_swrst & i_reg_wdata[`DPC_SWRST_BIT];
        end
    end
    assign o_soft_reset = soft_rst_q;

    // Host port mode survives software reset
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_spi_mode <= `DPC_SPI_RST;
        end else if (i_spi_detect) begin
            o_spi_mode <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (regs_rst) begin
            o_dac_low_power <= `DPC_LP_RST;
        end else if (wr_lp) begin
            o_dac_low_power <= i_reg_wdata[`DPC_LP_MSB:`DPC_LP_LSB];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (regs_rst) begin
            o_auto_pd_en <= `DPC_AUTO_RST;
        end else if (wr_cab) begin
            o_auto_pd_en <= i_reg_wdata[`DPC_CAB_AUTO_BIT];
        end
    end

    // Monitoring selection; standard-independent by construction
    dpc_pkg::dpc_out_cfg_t cfg;
    logic mon1;
    logic mon2;
    logic absent1;
    logic absent2;
    assign cfg = dpc_pkg::dpc_out_cfg_t'(i_out_cfg);
    assign mon1 = i_cable_det_en & i_dac_pwr_up[0];
    assign mon2 = i_cable_det_en & i_dac_pwr_up[1]
                  & (cfg == dpc_pkg::DPC_CFG_CVBS_YC);
    assign absent1 = mon1 & ~present_s[0];
    assign absent2 = mon2 & ~present_s[1];

    // Status written only by the frame check; host writes reach it only through the software reset, which restores 2'h3
    always_ff @(posedge i_sys_clk) begin
        if (regs_rst) begin
            o_cable_status <= `DPC_CAB_STAT_RST;
        end else if (i_frame_start) begin
            if (mon1) begin
                o_cable_status[0] <= ~present_s[0];
            end
            if (mon2) begin
                o_cable_status[1] <= ~present_s[1];
            end
        end
    end

    dpc_pkg::dpc_dac_vec_t pd_d;
    always_comb begin
        unique case (cfg)
            dpc_pkg::DPC_CFG_CVBS_YC: begin
                pd_d = {absent2, absent2, absent1};
            end
            dpc_pkg::DPC_CFG_COMPONENT: begin
                pd_d = {3{absent1}};
            end
        endcase
    end

    // Decision latched at frame start, held while auto power-down and cable detection stay on
    always_ff @(posedge i_sys_clk) begin
        if (regs_rst) begin
            o_dac_auto_pd <= `DPC_PD_RST;
        end else if (!(o_auto_pd_en && i_cable_det_en)) begin
            o_dac_auto_pd <= `DPC_PD_RST;
        end else if (i_frame_start) begin
            o_dac_auto_pd <= pd_d;
        end
    end

    // Pin readback, refreshed every pixel clock while it runs
    logic [PIN_W-1:0] rb_q;
    always_ff @(posedge i_sys_clk) begin
        if (regs_rst) begin
            rb_q <= '0;
        end else begin
            rb_q <= sync_out[PIN_W-1:0];
        end
    end

    logic [PIX_W-1:0] rb_s;
    logic [PIX_W-1:0] rb_y;
    logic [PIX_W-1:0] rb_c;
    logic [5:0] rb_ctl;
    assign rb_s = rb_q[PIX_W-1:0];
    assign rb_y = rb_q[2*PIX_W-1:PIX_W];
    assign rb_c = rb_q[3*PIX_W-1:2*PIX_W];
    assign rb_ctl = rb_q[PIN_W-1:3*PIX_W];

    logic [`DPC_DATA_W-1:0] rdata_d;
    always_comb begin
        rdata_d = 8'h00;
        unique case (i_reg_addr)
            `DPC_OFS_LOW_POWER: begin
                rdata_d = {5'h00, o_dac_low_power};
            end
            `DPC_OFS_CABLE: begin
                rdata_d = {3'h0, o_auto_pd_en, 2'h0, o_cable_status};
            end
            8'h12: begin
                rdata_d = rb_s[9:2];
            end
            8'h13: begin
                rdata_d = rb_y[9:2];
            end
            8'h14: begin
                rdata_d = rb_c[9:2];
            end
            8'h15: begin
                rdata_d = {rb_s[1:0], rb_y[1:0], rb_c[1:0], 2'h0};
            end
            `DPC_OFS_RB_LAST: begin
                rdata_d = {2'h0, rb_ctl};
            end
            `DPC_OFS_SWRST: begin
                rdata_d = 8'h00;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_d;
            end
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_swrst_write;
        wr_swrst && i_reg_wdata[`DPC_SWRST_BIT];
    endsequence

    sequence s_swrst_done;
        soft_rst_q ##1 (o_dac_low_power == 3'h0 && !o_auto_pd_en
                        && o_dac_auto_pd == 3'h0 && !soft_rst_q);
    endsequence

    a_lp_reset_clear: assert property (
        @(posedge i_sys_clk) disable iff (1'b0)
        i_srst |=> o_dac_low_power == 3'h0)
        else $error("low power enables not cleared by reset");

    a_lp_write_apply: assert property (
        wr_lp && !soft_rst_q |=> o_dac_low_power == $past(i_reg_wdata[2:0]))
        else $error("low power write not applied");

    a_status_dac1: assert property (
        i_frame_start && mon1 && !soft_rst_q
        |=> o_cable_status[0] == !$past(present_s[0]))
        else $error("DAC 1 status not updated at frame start");

    a_dac2_ignored: assert property (
        i_frame_start && cfg == dpc_pkg::DPC_CFG_COMPONENT && !soft_rst_q
        |=> $stable(o_cable_status[1]))
        else $error("DAC 2 status changed in component configuration");

    a_status_ro: assert property (
        !i_frame_start && !soft_rst_q |=> $stable(o_cable_status))
        else $error("cable status changed outside a frame check");

    a_pd_component: assert property (
        i_frame_start && o_auto_pd_en && mon1 && !present_s[0]
        && cfg == dpc_pkg::DPC_CFG_COMPONENT && !soft_rst_q
        |=> o_dac_auto_pd == 3'h7)
        else $error("component cable loss did not power down all DACs");

    a_pd_cvbs_dac2: assert property (
        i_frame_start && o_auto_pd_en && mon1 && present_s[0] && mon2
        && !present_s[1] && !soft_rst_q
        |=> o_dac_auto_pd == 3'h6)
        else $error("DAC 2 cable loss did not power down DAC 2 and 3");

    a_pd_disabled: assert property (
        !i_cable_det_en |=> o_dac_auto_pd == 3'h0)
        else $error("auto power-down active without cable detection");

    a_pd_hold_frame: assert property (
        !i_frame_start && o_auto_pd_en && i_cable_det_en && !soft_rst_q
        |=> $stable(o_dac_auto_pd))
        else $error("power-down decision changed within a frame");

    a_swrst_selfclear: assert property (
        s_swrst_write |=> s_swrst_done)
        else $error("software reset did not pulse once and restore defaults");

    a_spi_kept: assert property (
        o_spi_mode && soft_rst_q |=> o_spi_mode [*2])
        else $error("software reset left SPI mode");

    a_status_dac2: assert property (
        i_frame_start && mon2 && !soft_rst_q
        |=> o_cable_status[1] == !$past(present_s[1]))
        else $error("DAC 2 status not updated at frame start");

    a_pd_cvbs_dac1: assert property (
        i_frame_start && o_auto_pd_en && mon1 && !present_s[0] && mon2
        && present_s[1] && !soft_rst_q
        |=> o_dac_auto_pd == 3'h1)
        else $error("DAC 1 cable loss did not power down DAC 1 alone");

    a_swrst_reads_zero: assert property (
        i_reg_rd && hit(i_reg_addr, `DPC_OFS_SWRST)
        |=> o_reg_rdata == 8'h00)
        else $error("software reset bit did not read back zero");

    a_read_answer: assert property (
        i_reg_rd |=> o_reg_rvalid)
        else $error("read strobe not answered in the next cycle");

endmodule : dpc_ctrl

/* dpc_cable_model.sv */
/*
 * Cable and load model on the DAC 1 and DAC 2 outputs.
 * Assumes the bench says which cables are plugged in.
 */
`timescale 1ns/100ps

module dpc_cable_model #(
    parameter int SETTLE = 2
) (
    input wire logic i_sys_clk,
    input wire logic [1:0] i_attach,
    output logic [1:0] o_cable_present
);
    logic [1:0] pipe_q [SETTLE];

    // Sense level lags a plug event, like a slow analog comparator
    always_ff @(posedge i_sys_clk) begin
        pipe_q[0] <= i_attach;
        for (int i = 1; i < SETTLE; i++) begin
            pipe_q[i] <= pipe_q[i-1];
        end
    end

    assign o_cable_present = pipe_q[SETTLE-1];
endmodule : dpc_cable_model

/* testbench.sv */
/*
 * Self-checking bench for dpc_ctrl.
 * Assumes dpc_params.svh, dpc_pkg and the cable model compile first.
 */
`timescale 1ns/100ps
`include "dpc_params.svh"

module testbench;
    logic sys_clk, srst, wr, rd, rvalid, spi_det, spi_mode, soft_rst;
    logic frame, det_en, cfg, ser_out, auto_en;
    logic [7:0] addr, wdata, rdata;
    logic [2:0] pwr, low_power, auto_pd, exp_pd;
    logic [1:0] attach, present, status, exp_st;
    logic [9:0] pix_s, pix_y, pix_c;
    logic [4:0] syn;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    // Each entry is {cfg, det_en, pwr_up[2:0], attach[1:0]}
    logic [6:0] cases [10] = '{7'h3F, 7'h3E, 7'h3D, 7'h3C, 7'h7C,
                               7'h7F, 7'h7D, 7'h38, 7'h1C, 7'h3C};

    dpc_ctrl dpc_ctrl_i (
        .i_sys_clk(sys_clk),
        .i_srst(srst),
        .i_reg_addr(addr),
        .i_reg_wr(wr),
        .i_reg_wdata(wdata),
        .i_reg_rd(rd),
        .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid),
        .i_spi_detect(spi_det),
        .o_spi_mode(spi_mode),
        .o_soft_reset(soft_rst),
        .i_frame_start(frame),
        .i_cable_det_en(det_en),
        .i_out_cfg(cfg),
        .i_dac_pwr_up(pwr),
        .i_cable_present(present),
        .i_pix_s(pix_s),
        .i_pix_y(pix_y),
        .i_pix_c(pix_c),
        .i_s_hsync_n(syn[0]),
        .i_s_vsync_n(syn[1]),
        .i_p_hsync_n(syn[2]),
        .i_p_vsync_n(syn[3]),
        .i_p_blank_n(syn[4]),
        .i_subcarrier_lock_or_serial_out(ser_out),
        .o_dac_low_power(low_power),
        .o_dac_auto_pd(auto_pd),
        .o_cable_status(status),
        .o_auto_pd_en(auto_en)
    );

    dpc_cable_model dpc_cable_model_i (
        .i_sys_clk(sys_clk),
        .i_attach(attach),
        .o_cable_present(present)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] m,
                          input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        chk(8'(rvalid), 8'h01);
        chk(rdata & m, e);
    endtask : rd_reg

    // Auto power-down is assumed enabled while frames run
    task automatic run_frame(input logic [6:0] c);
        logic a1;
        logic a2;
        @(posedge sys_clk);
        {cfg, det_en, pwr, attach} <= c;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(8'(status), 8'(exp_st));
        chk(8'(auto_pd), 8'(exp_pd & {3{c[5]}}));
        a1 = c[5] & c[2] & ~c[0];
        a2 = c[5] & c[3] & ~c[6] & ~c[1];
        if (c[5] && c[2]) exp_st[0] = ~c[0];
        if (c[5] && c[3] && !c[6]) exp_st[1] = ~c[1];
        exp_pd = c[6] ? {3{a1}} : {a2, a2, a1};
        @(posedge sys_clk);
        frame <= 1'b1;
        @(posedge sys_clk);
        frame <= 1'b0;
        @(negedge sys_clk);
        chk(8'(status), 8'(exp_st));
        chk(8'(auto_pd), 8'(exp_pd));
    endtask : run_frame

    initial begin
        {wr, rd, spi_det, frame, det_en, cfg, ser_out} = '0;
        {addr, wdata, pix_s, pix_y, pix_c, syn} = '0;
        {pwr, attach} = 5'h1F;
        srst = 1'b1;
        exp_st = 2'h3;
        exp_pd = 3'h0;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        chk(8'(low_power), 8'h00);
        rd_reg(`DPC_OFS_LOW_POWER, 8'h07, 8'h00);
        rd_reg(`DPC_OFS_CABLE, 8'h13, 8'h03);
        for (int i = 0; i < 3; i++) begin
            wr_reg(`DPC_OFS_LOW_POWER, 8'h01 << i);
            @(negedge sys_clk);
            chk(8'(low_power), 8'h01 << i);
        end
        wr_reg(`DPC_OFS_LOW_POWER, 8'h05);
        rd_reg(`DPC_OFS_LOW_POWER, 8'h07, 8'h05);
        wr_reg(`DPC_OFS_CABLE, 8'h10);
        @(negedge sys_clk);
        chk(8'(auto_en), 8'h01);
        foreach (cases[i]) begin
            run_frame(cases[i]);
        end
        wr_reg(`DPC_OFS_CABLE, 8'h00);
        repeat (2) @(negedge sys_clk);
        chk(8'(auto_pd), 8'h00);
        wr_reg(`DPC_OFS_CABLE, 8'h10);
        rd_reg(`DPC_OFS_CABLE, 8'h13, 8'h13);
        @(posedge sys_clk);
        pix_s <= 10'h2A5;
        pix_y <= 10'h15A;
        pix_c <= 10'h3C3;
        syn <= 5'h15;
        ser_out <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd_reg(8'h12, 8'hFF, pix_s[9:2]);
        rd_reg(8'h13, 8'hFF, pix_y[9:2]);
        rd_reg(8'h14, 8'hFF, pix_c[9:2]);
        rd_reg(8'h15, 8'hFF, {pix_s[1:0],pix_y[1:0],pix_c[1:0],2'h0});
        rd_reg(`DPC_OFS_RB_LAST, 8'hFF, {2'h0, ser_out, syn});
        wr_reg(`DPC_OFS_RB_FIRST, 8'h00);
        rd_reg(`DPC_OFS_RB_FIRST, 8'hFF, pix_s[9:2]);
        rd_reg(8'h20, 8'hFF, 8'h00);
        @(posedge sys_clk);
        spi_det <= 1'b1;
        @(posedge sys_clk);
        spi_det <= 1'b0;
        wr_reg(`DPC_OFS_LOW_POWER, 8'h07);
        wr_reg(`DPC_OFS_SWRST, 8'h02);
        @(negedge sys_clk);
        chk(8'(soft_rst), 8'h01);
        @(negedge sys_clk);
        chk(8'({low_power, auto_en, status, spi_mode}), 8'h07);
        chk(8'(soft_rst), 8'h00);
        rd_reg(`DPC_OFS_SWRST, 8'hFF, 8'h00);
        @(posedge sys_clk);
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        chk(8'(spi_mode), 8'h00);
        conclude();
    end
endmodule : testbench
